// ==== cmd_pkg.sv ====
package cmd_pkg;
	// task-file and control register byte addresses
	localparam logic [7:0] OFS_FEAT = 8'h04;
	localparam logic [7:0] OFS_SECCNT = 8'h08;
	localparam logic [7:0] OFS_LBA_LO = 8'h0c;
	localparam logic [7:0] OFS_LBA_MID = 8'h10;
	localparam logic [7:0] OFS_LBA_HI = 8'h14;
	localparam logic [7:0] OFS_DEVHEAD = 8'h18;
	localparam logic [7:0] OFS_CMD = 8'h1c;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
	localparam logic [7:0] OFS_MAX_LO = 8'h28;
	localparam logic [7:0] OFS_MAX_HI = 8'h2c;
	localparam logic [7:0] OFS_MULT = 8'h30;
	localparam logic [7:0] OFS_IDENT82 = 8'h34;
	// command codes
	localparam logic [7:0] CMD_RD_NATIVE = 8'hf8;
	localparam logic [7:0] CMD_SET_MAX = 8'hf9;
	localparam logic [7:0] CMD_SET_MAX_EXT = 8'h37;
	localparam logic [7:0] CMD_SET_MULT = 8'hc6;
	localparam logic [7:0] CMD_SLEEP_A = 8'he6;
	localparam logic [7:0] CMD_SLEEP_B = 8'h99;
	localparam logic [7:0] CMD_SMART = 8'hb0;
	// max-address subcommands in the features register
	localparam logic [7:0] SUB_SET_ADDR = 8'h00;
	localparam logic [7:0] SUB_SET_PWD = 8'h01;
	localparam logic [7:0] SUB_LOCK = 8'h02;
	localparam logic [7:0] SUB_UNLOCK = 8'h03;
	localparam logic [7:0] SUB_FREEZE = 8'h04;
	// self-monitoring signature
	localparam logic [7:0] SMART_SIG_HI = 8'hc2;
	localparam logic [7:0] SMART_SIG_LO = 8'h4f;
	// field positions
	localparam int LBA_MODE_BIT = 6;
	localparam int DRIVE_SEL_BIT = 4;
	localparam int KEEP_BIT = 0;
	localparam int ST_BUSY_BIT = 7;
	localparam int ST_RDY_BIT = 6;
	localparam int ST_SLEEP_BIT = 5;
	localparam int ST_ERR_BIT = 0;
	localparam int ERR_ABORT_BIT = 2;
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_SLEEP_BIT = 1;
	localparam int IRQ_W = 2;
	localparam logic [15:0] IDENT82_VAL = 16'h0001;
	// idle timer, maximum and block size defaults, execution states
	localparam int unsigned IDLE_TIME_US = 5000;
	localparam int unsigned CLK_MHZ = 40;
	localparam int unsigned IDLE_CYCLES_DEF = IDLE_TIME_US * CLK_MHZ;
	localparam logic [47:0] NATIVE_MAX_DEF = 48'h0000_00ff_ffff;
	localparam int unsigned MAX_BLOCK_DEF = 16;
	typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_DONE} exec_state_t;
endpackage

// ==== host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module host_model
	import cmd_pkg::*;
(
	input wire logic pclk, // clock
	output logic psel, // select
	output logic penable, // access phase
	output logic pwrite, // direction
	output logic [7:0] paddr, // byte address
	output logic [31:0] pwdata, // write data
	input wire logic pready, // ready
	input wire logic [31:0] prdata, // read data
	input wire logic pslverr // error
);
	logic [31:0] rdat;
	logic rerr;
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// released write data must not keep its last value
		pwdata <= ~d;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a);
		xfer(1'b0, a, 32'h0);
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic load(input logic [7:0] feat, cnt, lo, mid, hi, dh);
		wr(OFS_FEAT, {24'h0, feat});
		wr(OFS_SECCNT, {24'h0, cnt});
		wr(OFS_LBA_LO, {24'h0, lo});
		wr(OFS_LBA_MID, {24'h0, mid});
		wr(OFS_LBA_HI, {24'h0, hi});
		wr(OFS_DEVHEAD, {24'h0, dh});
	endtask
	// issue a command, wait for busy to drop, return the abort flag
	task automatic run(input logic [7:0] code, output logic abort);
		wr(OFS_CMD, {24'h0, code});
		rdat = 32'h80;
		while (rdat[ST_BUSY_BIT] !== 1'b0)
			rd(OFS_CMD);
		rd(OFS_FEAT);
		abort = rdat[ERR_ABORT_BIT];
	endtask
	// read the native maximum first, then load the task file and issue the command
	task automatic maxset(input logic [7:0] code, feat, cnt, lo, mid, hi,
		input logic [3:0] top, output logic abort);
		logic a;
		run(CMD_RD_NATIVE, a);
		load(feat, cnt, lo, mid, hi, {4'h4, top});
		run(code, abort);
	endtask
endmodule
`default_nettype wire

// ==== hpa_multiple_sleep_cmd_decoder.sv ====
// Behaviour
// - F9h loads 28-bit maximum from head nibble and cylinder/sector bytes.
// - sector-count bit 0 keeps the maximum over hardware reset (power-up reset restores the native maximum); else revert.
// - features 01h-04h password, lock, unlock, freeze; others not executed.
// - second nonvolatile max-address after reset is aborted.
// - 37h loads 48-bit maximum from previous and current address writes.
// - C6h with valid nonzero count sets block size and enables multiple.
// - unsupported block count aborts and disables multiple commands.
// - block count zero disables multiple commands.
// - multiple commands are disabled after power-on.
// - E6h/99h set busy, enter sleep, clear busy, raise interrupt.
// - any command written while asleep wakes and executes.
// - idle timer of 5 ms puts the device to sleep.
// - identify word 82 bit 0 reports self-monitoring support.
//
// The address map and the APB register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module hpa_multiple_sleep_cmd_decoder
	import cmd_pkg::*;
#(
	parameter int unsigned IDLE_CYCLES = cmd_pkg::IDLE_CYCLES_DEF,
	parameter int unsigned MAX_BLOCK = cmd_pkg::MAX_BLOCK_DEF,
	parameter logic [47:0] NATIVE_MAX = cmd_pkg::NATIVE_MAX_DEF
) (
	input wire logic pclk, // clock, 40 MHz
	input wire logic presetn, // power-up reset, async, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic pready, // apb ready
	output logic [31:0] prdata, // apb read data
	output logic pslverr, // apb error on unmapped address
	input wire logic hw_reset_pin, // hardware reset request, async pin
	output logic irq, // level interrupt
	output logic sleep_active // device asleep
);
	import cmd_pkg::*;

	logic [7:0] feat_q, seccnt_q, lba_lo_q, lba_mid_q, lba_hi_q, devhead_q;
	logic [7:0] seccnt_p_q, lba_lo_p_q, lba_mid_p_q, lba_hi_p_q;
	logic [7:0] cmd_q;
	logic [IRQ_W-1:0] ist_q, imask_q;
	logic [47:0] max_q, nv_max_q, new_max_c;
	logic [15:0] pwd_q;
	logic [7:0] mult_cnt_q;
	logic mult_en_q, rnm_ok_q, nv_done_q, lock_q, frozen_q;
	logic err_q, sleep_q, abort_c, mult_ok_c, is_setmax_c;
	logic hr_s1_q, hr_s2_q, hr_s3_q, hr_f_q, hrst_ev_q;
	logic timer_exp, acc, wr_acc, cmd_wr;
	logic [31:0] rd_c;
	logic map_c;
	exec_state_t state_q;

	// block count register is eight bits wide
	if (MAX_BLOCK < 1 || MAX_BLOCK > 128)
	begin : g_bad_block
		$error("MAX_BLOCK must be 1..128");
	end

	////////////////////////////////////////////////////////////////////
	// apb slave
	assign acc = psel && penable && pready;
	assign wr_acc = acc && pwrite;
	assign cmd_wr = wr_acc && paddr == OFS_CMD && state_q == ST_IDLE;

	always_comb
	begin
		rd_c = '0;
		map_c = 1'b1;
		unique case (paddr)
			OFS_FEAT: rd_c = {24'h0, 5'h0, err_q, 2'h0};
			OFS_SECCNT: rd_c = {24'h0, seccnt_q};
			OFS_LBA_LO: rd_c = {24'h0, lba_lo_q};
			OFS_LBA_MID: rd_c = {24'h0, lba_mid_q};
			OFS_LBA_HI: rd_c = {24'h0, lba_hi_q};
			OFS_DEVHEAD: rd_c = {24'h0, devhead_q};
			OFS_CMD: rd_c = {24'h0, state_q != ST_IDLE, !sleep_q,
				sleep_q, 4'h0, err_q};
			OFS_IRQ_STAT: rd_c = {{(32-IRQ_W){1'b0}}, ist_q};
			OFS_IRQ_MASK: rd_c = {{(32-IRQ_W){1'b0}}, imask_q};
			OFS_MAX_LO: rd_c = max_q[31:0];
			OFS_MAX_HI: rd_c = {16'h0, max_q[47:32]};
			OFS_MULT: rd_c = {23'h0, mult_en_q, mult_cnt_q};
			OFS_IDENT82: rd_c = {16'h0, IDENT82_VAL};
			default: map_c = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			prdata <= '0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel && penable && !pready;
			if (psel && penable && !pready)
			begin
				prdata <= pwrite ? 32'h0 : rd_c;
				pslverr <= !map_c;
			end
			else
				pslverr <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// task file, count and address registers two-deep for 48-bit addressing; ignored while busy
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			feat_q <= '0;
			seccnt_q <= '0;
			lba_lo_q <= '0;
			lba_mid_q <= '0;
			lba_hi_q <= '0;
			devhead_q <= '0;
			seccnt_p_q <= '0;
			lba_lo_p_q <= '0;
			lba_mid_p_q <= '0;
			lba_hi_p_q <= '0;
			cmd_q <= '0;
		end
		else if (wr_acc && state_q == ST_IDLE)
		begin
			unique case (paddr)
				OFS_FEAT: feat_q <= pwdata[7:0];
				OFS_SECCNT:
				begin
					seccnt_p_q <= seccnt_q;
					seccnt_q <= pwdata[7:0];
				end
				OFS_LBA_LO:
				begin
					lba_lo_p_q <= lba_lo_q;
					lba_lo_q <= pwdata[7:0];
				end
				OFS_LBA_MID:
				begin
					lba_mid_p_q <= lba_mid_q;
					lba_mid_q <= pwdata[7:0];
				end
				OFS_LBA_HI:
				begin
					lba_hi_p_q <= lba_hi_q;
					lba_hi_q <= pwdata[7:0];
				end
				OFS_DEVHEAD: devhead_q <= pwdata[7:0];
				OFS_CMD: cmd_q <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// hardware reset pin: three stages, change taken once the second and third stages agree
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			hr_s1_q <= 1'b0;
			hr_s2_q <= 1'b0;
			hr_s3_q <= 1'b0;
			hr_f_q <= 1'b0;
			hrst_ev_q <= 1'b0;
		end
		else
		begin
			hr_s1_q <= hw_reset_pin;
			hr_s2_q <= hr_s1_q;
			hr_s3_q <= hr_s2_q;
			if (hr_s2_q == hr_s3_q)
				hr_f_q <= hr_s3_q;
			hrst_ev_q <= hr_s2_q == hr_s3_q && hr_s3_q && !hr_f_q;
		end
	end

	////////////////////////////////////////////////////////////////////
	// command decode
	always_comb
	begin
		abort_c = 1'b0;
		is_setmax_c = cmd_q == CMD_SET_MAX || cmd_q == CMD_SET_MAX_EXT;
		mult_ok_c = ((seccnt_q & (seccnt_q - 8'h01)) == 8'h00) &&
			32'(seccnt_q) <= MAX_BLOCK;
		if (cmd_q == CMD_SET_MAX)
			new_max_c = {20'h0, devhead_q[3:0], lba_hi_q, lba_mid_q,
				lba_lo_q};
		else
			new_max_c = {lba_hi_p_q, lba_mid_p_q, lba_lo_p_q, lba_hi_q,
				lba_mid_q, lba_lo_q};
		unique case (cmd_q)
			CMD_RD_NATIVE: abort_c = 1'b0;
			CMD_SET_MAX, CMD_SET_MAX_EXT:
			begin
				if (!rnm_ok_q || !devhead_q[LBA_MODE_BIT])
					abort_c = 1'b1;
				else if (cmd_q == CMD_SET_MAX_EXT ||
					feat_q == SUB_SET_ADDR)
					abort_c = lock_q || frozen_q ||
						(seccnt_q[KEEP_BIT] && nv_done_q);
				else
				begin
					unique case (feat_q)
						SUB_SET_PWD: abort_c = lock_q || frozen_q;
						SUB_LOCK: abort_c = frozen_q;
						SUB_UNLOCK: abort_c = frozen_q ||
							pwd_q != {lba_mid_q, lba_lo_q};
						SUB_FREEZE: abort_c = 1'b0;
						default: abort_c = 1'b1;
					endcase
				end
			end
			CMD_SET_MULT: abort_c = seccnt_q != 8'h00 && !mult_ok_c;
			CMD_SLEEP_A, CMD_SLEEP_B: abort_c = 1'b0;
			CMD_SMART: abort_c = lba_hi_q != SMART_SIG_HI ||
				lba_mid_q != SMART_SIG_LO;
			default: abort_c = 1'b1;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_q <= ST_IDLE;
		else
		begin
			unique case (state_q)
				ST_IDLE: if (cmd_wr) state_q <= ST_EXEC;
				ST_EXEC: state_q <= ST_DONE;
				ST_DONE: state_q <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// execution: maximum address, locks, block count, sleep
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			max_q <= NATIVE_MAX;
			nv_max_q <= NATIVE_MAX;
			nv_done_q <= 1'b0;
			rnm_ok_q <= 1'b0;
			lock_q <= 1'b0;
			frozen_q <= 1'b0;
			pwd_q <= '0;
			mult_en_q <= 1'b0;
			mult_cnt_q <= '0;
			err_q <= 1'b0;
			sleep_q <= 1'b0;
		end
		else if (hrst_ev_q)
		begin
			max_q <= nv_max_q;
			nv_done_q <= 1'b0;
			rnm_ok_q <= 1'b0;
			lock_q <= 1'b0;
			frozen_q <= 1'b0;
			mult_en_q <= 1'b0;
			err_q <= 1'b0;
			sleep_q <= 1'b0;
		end
		else if (cmd_wr)
		begin
			sleep_q <= 1'b0;
			err_q <= 1'b0;
		end
		else if (state_q == ST_EXEC)
		begin
			err_q <= abort_c;
			rnm_ok_q <= cmd_q == CMD_RD_NATIVE;
			if (!abort_c)
			begin
				unique case (cmd_q)
					CMD_SET_MAX, CMD_SET_MAX_EXT:
					begin
						if (cmd_q == CMD_SET_MAX_EXT ||
							feat_q == SUB_SET_ADDR)
						begin
							max_q <= new_max_c;
							if (seccnt_q[KEEP_BIT])
							begin
								nv_max_q <= new_max_c;
								nv_done_q <= 1'b1;
							end
						end
						else if (feat_q == SUB_SET_PWD)
							pwd_q <= {lba_mid_q, lba_lo_q};
						else if (feat_q == SUB_LOCK)
							lock_q <= 1'b1;
						else if (feat_q == SUB_UNLOCK)
							lock_q <= 1'b0;
						else
							frozen_q <= 1'b1;
					end
					CMD_SET_MULT:
					begin
						mult_en_q <= seccnt_q != 8'h00;
						mult_cnt_q <= seccnt_q;
					end
					CMD_SLEEP_A, CMD_SLEEP_B: sleep_q <= 1'b1;
					default: ;
				endcase
			end
			else if (cmd_q == CMD_SET_MULT)
				mult_en_q <= 1'b0;
		end
		else if (timer_exp && state_q == ST_IDLE)
			sleep_q <= 1'b1;
	end

	idle_timer #(
		.CYCLES(IDLE_CYCLES)
	) u_idle_timer (
		.pclk(pclk),
		.presetn(presetn),
		.restart(state_q != ST_IDLE || sleep_q || cmd_wr),
		.expire(timer_exp)
	);

	////////////////////////////////////////////////////////////////////
	// interrupts: set wins over write-one-to-clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ist_q <= '0;
			imask_q <= '0;
			irq <= 1'b0;
			sleep_active <= 1'b0;
		end
		else
		begin
			if (wr_acc && paddr == OFS_IRQ_MASK)
				imask_q <= pwdata[IRQ_W-1:0];
			ist_q[IRQ_DONE_BIT] <= (state_q == ST_DONE) ||
				(ist_q[IRQ_DONE_BIT] && !(wr_acc &&
				paddr == OFS_IRQ_STAT && pwdata[IRQ_DONE_BIT]));
			ist_q[IRQ_SLEEP_BIT] <= (timer_exp && state_q == ST_IDLE &&
				!sleep_q && !cmd_wr) || (ist_q[IRQ_SLEEP_BIT] &&
				!(wr_acc && paddr == OFS_IRQ_STAT &&
				pwdata[IRQ_SLEEP_BIT]));
			irq <= |(ist_q & imask_q);
			sleep_active <= sleep_q;
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks
	AST_SLEEP_ORDER: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == ST_EXEC && !hrst_ev_q && (cmd_q == CMD_SLEEP_A ||
		cmd_q == CMD_SLEEP_B) |=> sleep_q && state_q == ST_DONE ##1
		state_q == ST_IDLE && ist_q[IRQ_DONE_BIT])
		else $error("sleep command sequence wrong");
	AST_WAKE: assert property (@(posedge pclk) disable iff (!presetn)
		cmd_wr && sleep_q && !hrst_ev_q |=> !sleep_q &&
		state_q == ST_EXEC)
		else $error("command did not wake device");
	AST_IDLE_SLEEP: assert property (@(posedge pclk) disable iff (!presetn)
		timer_exp && state_q == ST_IDLE && !cmd_wr && !hrst_ev_q
		|=> sleep_q)
		else $error("idle expiry did not sleep");
	AST_MULT_OK: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == ST_EXEC && !hrst_ev_q && cmd_q == CMD_SET_MULT &&
		seccnt_q != 8'h00 && mult_ok_c |=> mult_en_q && !err_q &&
		mult_cnt_q == $past(seccnt_q))
		else $error("block count not taken");
	AST_MULT_BAD: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == ST_EXEC && !hrst_ev_q && cmd_q == CMD_SET_MULT &&
		!mult_ok_c |=> !mult_en_q && err_q)
		else $error("unsupported block count not aborted");
	AST_MULT_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == ST_EXEC && !hrst_ev_q && cmd_q == CMD_SET_MULT &&
		seccnt_q == 8'h00 |=> !mult_en_q && !err_q)
		else $error("zero count did not disable");
	AST_MAX28: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == ST_EXEC && !hrst_ev_q && cmd_q == CMD_SET_MAX &&
		!abort_c && feat_q == SUB_SET_ADDR |=> max_q ==
		{20'h0, $past(devhead_q[3:0]), $past(lba_hi_q),
		$past(lba_mid_q), $past(lba_lo_q)})
		else $error("28-bit maximum wrong");
	AST_MAX48: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == ST_EXEC && !hrst_ev_q && cmd_q == CMD_SET_MAX_EXT &&
		!abort_c |=> max_q[47:24] == {$past(lba_hi_p_q),
		$past(lba_mid_p_q), $past(lba_lo_p_q)})
		else $error("48-bit maximum high part wrong");
	AST_NO_RNM: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == ST_EXEC && !hrst_ev_q && is_setmax_c && !rnm_ok_q
		|=> err_q && $stable(max_q))
		else $error("max address without read-native not aborted");
	AST_NV_ONCE: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == ST_EXEC && !hrst_ev_q && cmd_q == CMD_SET_MAX_EXT &&
		nv_done_q && seccnt_q[KEEP_BIT] |=> err_q)
		else $error("second nonvolatile setting accepted");
	AST_HRST: assert property (@(posedge pclk) disable iff (!presetn)
		hrst_ev_q |=> max_q == $past(nv_max_q) && !mult_en_q)
		else $error("reset did not restore maximum");
	AST_FEAT_RSV: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == ST_EXEC && !hrst_ev_q && cmd_q == CMD_SET_MAX &&
		feat_q > SUB_FREEZE |=> err_q)
		else $error("reserved subcommand not aborted");
	AST_SMART: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == ST_EXEC && !hrst_ev_q && cmd_q == CMD_SMART
		|=> err_q == $past(lba_hi_q != SMART_SIG_HI ||
		lba_mid_q != SMART_SIG_LO))
		else $error("signature check wrong");
endmodule
`default_nettype wire

// ==== hpa_multiple_sleep_cmd_decoder_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module hpa_multiple_sleep_cmd_decoder_tb_top;
	import cmd_pkg::*;
	localparam int unsigned IDLE_N = 400;
	localparam logic [47:0] NATIVE = 48'h00ff_ffff_ffff;
	logic pclk, presetn, hw_reset_pin, ab;
	logic psel, penable, pwrite, pready, pslverr, irq, sleep_active;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	int failures, check_count;
	// {features, password low byte, abort expected}
	logic [16:0] sub_tab [10] = '{{8'h01, 8'h5a, 1'b0},
		{8'h02, 8'h5a, 1'b0}, {8'h00, 8'h5a, 1'b1}, {8'h03, 8'h00, 1'b1},
		{8'h03, 8'h5a, 1'b0}, {8'h00, 8'h5a, 1'b0}, {8'h05, 8'h5a, 1'b1},
		{8'hff, 8'h5a, 1'b1}, {8'h04, 8'h5a, 1'b0}, {8'h00, 8'h5a, 1'b1}};
	// {block count, abort expected, enable expected}
	logic [9:0] mult_tab [6] = '{{8'h08, 2'b01}, {8'h03, 2'b10},
		{8'h10, 2'b01}, {8'h00, 2'b00}, {8'h20, 2'b10}, {8'h01, 2'b01}};
	logic [7:0] slp [2] = '{CMD_SLEEP_A, CMD_SLEEP_B};
	hpa_multiple_sleep_cmd_decoder #(.IDLE_CYCLES(IDLE_N),
		.NATIVE_MAX(NATIVE)) DUT (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .hw_reset_pin(hw_reset_pin), .irq(irq),
		.sleep_active(sleep_active));
	host_model host (.pclk(pclk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr));
	initial
	begin
		pclk = 1'b0;
		forever
			#12.5 pclk = ~pclk;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] e, g);
		check_count++;
		if (g !== e)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rdm(input logic [7:0] a, input logic [31:0] m, e,
		input string nm);
		host.rd(a);
		chk(nm, e, host.rdat & m);
	endtask
	task automatic test_done;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge pclk);
		failures++;
		test_done;
	end
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		failures = 0;
		check_count = 0;
		presetn = 1'b0;
		hw_reset_pin = 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rdm(OFS_MULT, 32'h100, 32'h0, "multiple at power-on");
		rdm(OFS_IDENT82, 32'h1, 32'h1, "ident word 82");
		rdm(OFS_MAX_LO, '1, NATIVE[31:0], "max at power-on");
		host.rd(8'h3c);
		chk("unmapped", 32'h1, {host.rdat[30:0], host.rerr});
		host.load(8'h00, 8'h00, 8'h56, 8'h34, 8'h12, 8'h4a);
		host.run(CMD_SET_MAX, ab);
		chk("abort without native read", 32'h1, 32'(ab));
		host.maxset(CMD_SET_MAX, 8'h00, 8'h00, 8'h56, 8'h34, 8'h12, 4'ha, ab);
		chk("set max 28 abort", 32'h0, 32'(ab));
		rdm(OFS_MAX_LO, '1, 32'h0a123456, "max 28-bit");
		host.load(8'h00, 8'h00, 8'h05, 8'h66, 8'h00, 8'h40);
		host.maxset(CMD_SET_MAX_EXT, 8'h00, 8'h01, 8'h11, 8'h22, 8'h33, 4'h0,
			ab);
		rdm(OFS_MAX_LO, '1, 32'h05332211, "max 48-bit low");
		rdm(OFS_MAX_HI, '1, 32'h66, "max 48-bit high");
		host.maxset(CMD_SET_MAX_EXT, 8'h00, 8'h01, 8'h11, 8'h22, 8'h33, 4'h0,
			ab);
		chk("second keep set", 32'h1, 32'(ab));
		host.maxset(CMD_SET_MAX, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 4'h1, ab);
		rdm(OFS_MAX_LO, '1, 32'h01000000, "volatile max");
		hw_reset_pin <= 1'b1;
		repeat (6) @(posedge pclk);
		hw_reset_pin <= 1'b0;
		repeat (8) @(posedge pclk);
		rdm(OFS_MAX_LO, '1, 32'h05332211, "max after reset low");
		rdm(OFS_MAX_HI, '1, 32'h66, "max after reset high");
		foreach (sub_tab[i])
		begin
			host.maxset(CMD_SET_MAX, sub_tab[i][16:9], 8'h00, sub_tab[i][8:1],
				~sub_tab[i][8:1], 8'h00, 4'h0, ab);
			chk("subcommand abort", 32'(sub_tab[i][0]), 32'(ab));
		end
		foreach (mult_tab[i])
		begin
			host.load(8'h00, mult_tab[i][9:2], 8'h00, 8'h00, 8'h00, 8'h40);
			host.run(CMD_SET_MULT, ab);
			chk("block count abort", 32'(mult_tab[i][1]), 32'(ab));
			rdm(OFS_MULT, mult_tab[i][0] ? 32'h1ff : 32'h100,
				mult_tab[i][0] ? {23'h1, mult_tab[i][9:2]} : 32'h0,
				"multiple state");
		end
		host.wr(OFS_IRQ_MASK, 32'h3);
		host.wr(OFS_IRQ_STAT, 32'h3);
		foreach (slp[i])
		begin
			host.run(slp[i], ab);
			chk("asleep", 32'h1, 32'(sleep_active));
			rdm(OFS_IRQ_STAT, 32'h1, 32'h1, "done status");
			chk("irq raised", 32'h1, 32'(irq));
			host.wr(OFS_IRQ_STAT, 32'h1);
			repeat (2) @(posedge pclk);
			chk("irq cleared", 32'h0, 32'(irq));
			host.load(8'h00, 8'h00, 8'h00, SMART_SIG_LO, SMART_SIG_HI, 8'he0);
			host.run(CMD_SMART, ab);
			chk("monitor command abort", 32'h0, 32'(ab));
			chk("awake after command", 32'h0, 32'(sleep_active));
			host.wr(OFS_IRQ_STAT, 32'h1);
		end
		host.load(8'h00, 8'h00, 8'h00, SMART_SIG_LO, 8'h00, 8'he0);
		host.run(CMD_SMART, ab);
		chk("bad signature abort", 32'h1, 32'(ab));
		host.wr(OFS_IRQ_MASK, 32'h1);
		host.wr(OFS_IRQ_STAT, 32'h3);
		repeat (IDLE_N / 2) @(posedge pclk);
		chk("awake within idle period", 32'h0, 32'(sleep_active));
		repeat (IDLE_N / 2 + 20) @(posedge pclk);
		chk("idle sleep", 32'h1, 32'(sleep_active));
		chk("masked irq", 32'h0, 32'(irq));
		rdm(OFS_IRQ_STAT, 32'h2, 32'h2, "idle status");
		host.wr(OFS_IRQ_MASK, 32'h2);
		repeat (2) @(posedge pclk);
		chk("unmasked irq", 32'h1, 32'(irq));
		test_done;
	end
endmodule
`default_nettype wire

// ==== idle_timer.sv ====
`timescale 1ns/100ps
`default_nettype none
module idle_timer #(
	parameter int unsigned CYCLES = 200000
) (
	input wire logic pclk, // clock
	input wire logic presetn, // async reset, active low
	input wire logic restart, // hold the count at zero
	output logic expire // one-cycle pulse when the period ends
);
	localparam int W = $clog2(CYCLES + 1);
	localparam logic [W-1:0] LAST = W'(CYCLES - 1);

	logic [W-1:0] cnt_q;

	if (CYCLES < 2)
	begin : g_bad_cycles
		$error("idle_timer: CYCLES must be at least 2");
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt_q <= '0;
		else if (restart)
			cnt_q <= '0;
		else if (cnt_q == LAST)
			cnt_q <= '0;
		else
			cnt_q <= cnt_q + W'(1);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			expire <= 1'b0;
		else
			expire <= !restart && (cnt_q == LAST);
	end
endmodule
`default_nettype wire
